// file: rtl/dcgo_map.svh
// Constants of the gain and offset calibration datapath.
// Assumes inclusion by the package, the datapath module, the checker and the bench.
`ifndef DCGO_MAP_SVH
`define DCGO_MAP_SVH

// Datapath width and channel count
`define DCGO_N 14
`define DCGO_CH 16
`define DCGO_CHW 4
`define DCGO_WORD 24

// Power-on coefficient values
`define DCGO_GAIN_RST 14'h3FFE
`define DCGO_OFFS_RST 14'h2000
`define DCGO_CODE_RST 14'h0000

// Offset midscale and code limits, signed 18-bit arithmetic
`define DCGO_MID 18'sh02000
`define DCGO_MAX 18'sh03FFF

// Serial word field positions
`define DCGO_RW_BIT 22
`define DCGO_ADDR_HI 19
`define DCGO_ADDR_LO 16
`define DCGO_SEL_HI 15
`define DCGO_SEL_LO 14
`define DCGO_DATA_HI 13

// Two-wire bus: seven-bit device address (arbitrary default), bit count per byte
`define DCGO_TW_ADDR 7'h54
`define DCGO_TW_ACK_BIT 4'h8
`define DCGO_TW_LAST_BYTE 2'h2

`endif

// file: rtl/dcgo_pkg.sv
// Types of the gain and offset calibration datapath.
// Assumes dcgo_map.svh on the include path.
`include "dcgo_map.svh"

package dcgo_pkg;

    // Destination chosen by the register-select field
    typedef enum logic [1:0] {
        DCGO_SEL_SFR  = 2'h0,
        DCGO_SEL_GAIN = 2'h1,
        DCGO_SEL_OFFS = 2'h2,
        DCGO_SEL_CODE = 2'h3
    } dcgo_sel_t;

    // Two-wire receiver states, Gray along idle, address, data
    typedef enum logic [1:0] {
        DCGO_TW_IDLE = 2'h0,
        DCGO_TW_ADDR = 2'h1,
        DCGO_TW_DATA = 2'h3,
        DCGO_TW_SKIP = 2'h2
    } dcgo_tw_t;

    // Received serial word
    typedef struct packed {
        logic ab_sel;
        logic read_not_write;
        logic [1:0] zeros;
        logic [`DCGO_CHW-1:0] chan;
        dcgo_sel_t sel;
        logic [`DCGO_N-1:0] data;
    } dcgo_word_t;

    // Special function register write handed to the outside
    typedef struct packed {
        logic valid;
        logic [`DCGO_CHW-1:0] addr;
        logic [`DCGO_N-1:0] data;
    } dcgo_sfr_t;

endpackage

// file: rtl/dcgo_datapath.sv
// Calibration datapath: serial word receiver, register decode, per-channel
// gain and offset correction and double-buffered output codes.
// Assumes serial pins already synchronous to i_clk and sampled well above
// their bit rate.
`timescale 1ns/1ns
`include "dcgo_map.svh"

////////////////////////////////////////////////////////////////////////////////
// Notes on behaviour
// - Select 11 input code, 10 offset, 01 gain, 00 special function registers.
// - Each write word's data goes to the selected register of the addressed channel; select 00 sends it out on o_sfr_wr, channel as address.
// - Corrected code is (gain+2)/2^n times input code plus offset minus 2^(n-1).
// - Datapath width n is 14, or 12 on the twelve-bit variant.
// - Gain resets to all ones with LSB zero; its LSB is always zero.
// - Offset resets to midscale, meaning no offset.
// - Offset is offset-binary around midscale.
// - Gain is a fractional multiplier, all ones less LSB is unity.
// - Every channel has its own gain and offset registers.
// - Load strobe moves all buffered codes to the converters at once.
// - Interface-select input chooses synchronous serial port or two-wire bus.
// - Serial port is fully active only from the frame-select falling edge.
// - Word is 24 bits, MSB first: A/B, R/W, 00, channel, select, data.
// - Interface-select low is two-wire bus, high is serial port.
module dcgo_datapath
    import dcgo_pkg::*;
(
    // Clock, reset, enable
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_ce,
    // Interface select, high serial port, low two-wire
    input wire logic i_if_sel,
    // Synchronous serial port
    input wire logic i_frame_n,
    input wire logic i_sclk,
    input wire logic i_sdin,
    // Two-wire bus, open-drain data
    input wire logic i_scl,
    input wire logic i_sda_in,
    output logic o_sda_out,
    output logic o_sda_oe_n,
    // Load strobe
    input wire logic i_load_all_channels_strobe,
    // Converter core side
    output logic [`DCGO_CH*`DCGO_N-1:0] o_corrected_codes,
    output logic o_update,
    output dcgo_sfr_t o_sfr_wr,
    output logic o_if_active
);

    ////////////////////////////////////////////////////////////////////////////
    // Correction arithmetic with saturation
    function automatic logic [`DCGO_N-1:0] dcgo_correct(
        input logic [`DCGO_N-1:0] x,
        input logic [`DCGO_N-1:0] m,
        input logic [`DCGO_N-1:0] c
    );
        logic [2*`DCGO_N:0] prod;
        logic signed [17:0] sum;
        prod = ({1'b0, m} + 15'h0002) * {15'h0000, x};
        sum = $signed({3'b000, prod[2*`DCGO_N:`DCGO_N]}) + $signed({4'h0, c}) - `DCGO_MID;
        if (sum < 18'sh00000)
            dcgo_correct = '0;
        else if (sum > `DCGO_MAX)
            dcgo_correct = '1;
        else
            dcgo_correct = sum[`DCGO_N-1:0];
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Pin history for edge detection
    logic sclk_reg, frame_n_reg, scl_reg, sda_reg;

    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            sclk_reg <= 1'b0;
            frame_n_reg <= 1'b1;
            scl_reg <= 1'b1;
            sda_reg <= 1'b1;
        end
        else if (i_ce)
        begin
            sclk_reg <= i_sclk;
            frame_n_reg <= i_frame_n;
            scl_reg <= i_scl;
            sda_reg <= i_sda_in;
        end
    end

    // Edge decode
    wire spi_mode = i_if_sel;
    wire frame_fall = spi_mode & frame_n_reg & ~i_frame_n;
    wire frame_rise = spi_mode & ~frame_n_reg & i_frame_n;
    wire sclk_fall = spi_mode & ~i_frame_n & sclk_reg & ~i_sclk;
    wire tw_start = ~spi_mode & i_scl & scl_reg & sda_reg & ~i_sda_in;
    wire tw_stop = ~spi_mode & i_scl & scl_reg & ~sda_reg & i_sda_in;
    wire scl_rise = ~spi_mode & ~scl_reg & i_scl;
    wire scl_fall = ~spi_mode & scl_reg & ~i_scl;

    ////////////////////////////////////////////////////////////////////////////
    // Serial port: data taken on the falling serial clock, MSB first
    logic [`DCGO_WORD-1:0] spi_sh_reg;
    logic [4:0] spi_cnt_reg;
    logic spi_act_reg;
    wire spi_full = (spi_cnt_reg == 5'h18);

    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            spi_sh_reg <= '0;
            spi_cnt_reg <= '0;
            spi_act_reg <= 1'b0;
        end
        else if (i_ce)
        begin
            if (frame_fall)
            begin
                spi_cnt_reg <= '0;
                spi_act_reg <= 1'b1;
            end
            else if (frame_rise | ~spi_mode)
                spi_act_reg <= 1'b0;
            else if (sclk_fall & spi_act_reg & ~spi_full)
            begin
                spi_sh_reg <= {spi_sh_reg[`DCGO_WORD-2:0], i_sdin};
                spi_cnt_reg <= spi_cnt_reg + 5'h01;
            end
        end
    end

    // Short frames are discarded
    wire spi_done = frame_rise & spi_act_reg & spi_full;

    ////////////////////////////////////////////////////////////////////////////
    // Two-wire receiver: address byte then three data bytes per word
    dcgo_tw_t tw_state_reg, tw_state_next;
    logic [`DCGO_WORD-1:0] tw_sh_reg;
    logic [3:0] tw_bit_reg;
    logic [1:0] tw_byte_reg;
    logic tw_ack_reg;
    wire tw_ack_clk = scl_rise & (tw_bit_reg == `DCGO_TW_ACK_BIT);
    wire tw_match = (tw_sh_reg[7:1] == `DCGO_TW_ADDR) & ~tw_sh_reg[0];
    wire tw_done = tw_ack_clk & (tw_state_reg == DCGO_TW_DATA) & (tw_byte_reg == `DCGO_TW_LAST_BYTE);
    wire tw_ack_want = (tw_bit_reg == `DCGO_TW_ACK_BIT)
        & (((tw_state_reg == DCGO_TW_ADDR) & tw_match) | (tw_state_reg == DCGO_TW_DATA));

    // Next state of the two-wire receiver
    always_comb
    begin
        tw_state_next = tw_state_reg;
        if (tw_start)
            tw_state_next = DCGO_TW_ADDR;
        else if (tw_stop | spi_mode)
            tw_state_next = DCGO_TW_IDLE;
        else if (tw_ack_clk)
        begin
            unique case (tw_state_reg)
                DCGO_TW_ADDR: tw_state_next = tw_match ? DCGO_TW_DATA : DCGO_TW_SKIP;
                DCGO_TW_DATA: tw_state_next = DCGO_TW_DATA;
                DCGO_TW_SKIP: tw_state_next = DCGO_TW_SKIP;
                DCGO_TW_IDLE: tw_state_next = DCGO_TW_IDLE;
            endcase
        end
    end

    // Two-wire shift, bit and byte counting, acknowledge drive
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            tw_state_reg <= DCGO_TW_IDLE;
            tw_sh_reg <= '0;
            tw_bit_reg <= '0;
            tw_byte_reg <= '0;
            tw_ack_reg <= 1'b0;
        end
        else if (i_ce)
        begin
            tw_state_reg <= tw_state_next;
            if (tw_start)
            begin
                tw_bit_reg <= '0;
                tw_byte_reg <= '0;
                tw_ack_reg <= 1'b0;
            end
            else if (tw_ack_clk)
            begin
                tw_bit_reg <= '0;
                if (tw_state_reg == DCGO_TW_DATA)
                    tw_byte_reg <= tw_done ? 2'h0 : tw_byte_reg + 2'h1;
            end
            else if (scl_rise & (tw_state_reg != DCGO_TW_IDLE))
            begin
                tw_sh_reg <= {tw_sh_reg[`DCGO_WORD-2:0], i_sda_in};
                tw_bit_reg <= tw_bit_reg + 4'h1;
            end
            if (tw_stop | spi_mode)
                tw_ack_reg <= 1'b0;
            else if (scl_fall)
                tw_ack_reg <= tw_ack_want;
        end
    end

    // Open-drain data: only ever pulls low
    assign o_sda_out = 1'b0;
    assign o_sda_oe_n = ~tw_ack_reg;
    assign o_if_active = spi_act_reg | (tw_state_reg != DCGO_TW_IDLE);

    ////////////////////////////////////////////////////////////////////////////
    // Word decode, writes only
    wire dcgo_word_t word = spi_mode ? spi_sh_reg : tw_sh_reg;
    wire word_ok = (spi_done | tw_done) & ~word.read_not_write;
    wire wr_code = word_ok & (word.sel == DCGO_SEL_CODE);
    wire wr_offs = word_ok & (word.sel == DCGO_SEL_OFFS);
    wire wr_gain = word_ok & (word.sel == DCGO_SEL_GAIN);
    wire wr_sfr = word_ok & (word.sel == DCGO_SEL_SFR);
    // Two-wire word is taken whole at the last ack clock: the ack clock does not shift
    wire [`DCGO_N-1:0] wdata = word.data;

    ////////////////////////////////////////////////////////////////////////////
    // Per-channel input, offset, gain and output registers
    logic [`DCGO_N-1:0] code_reg [`DCGO_CH];
    logic [`DCGO_N-1:0] offs_reg [`DCGO_CH];
    logic [`DCGO_N-1:0] gain_reg [`DCGO_CH];
    logic [`DCGO_N-1:0] out_reg [`DCGO_CH];

    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            for (int i = 0; i < `DCGO_CH; i++)
            begin
                code_reg[i] <= `DCGO_CODE_RST;
                offs_reg[i] <= `DCGO_OFFS_RST;
                gain_reg[i] <= `DCGO_GAIN_RST;
                out_reg[i] <= `DCGO_CODE_RST;
            end
        end
        else if (i_ce)
        begin
            if (wr_code)
                code_reg[word.chan] <= wdata;
            if (wr_offs)
                offs_reg[word.chan] <= wdata;
            if (wr_gain)
                gain_reg[word.chan] <= {wdata[`DCGO_N-1:1], 1'b0};
            if (i_load_all_channels_strobe)
                for (int i = 0; i < `DCGO_CH; i++)
                    out_reg[i] <= dcgo_correct(code_reg[i], gain_reg[i], offs_reg[i]);
        end
    end

    // Update pulse and special function register handoff
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            o_update <= 1'b0;
            o_sfr_wr <= '0;
        end
        else if (i_ce)
        begin
            o_update <= i_load_all_channels_strobe;
            o_sfr_wr.valid <= wr_sfr;
            if (wr_sfr)
            begin
                o_sfr_wr.addr <= word.chan;
                o_sfr_wr.data <= wdata;
            end
        end
    end

    // Flatten output codes, channel 0 in the low bits
    always_comb
    begin
        for (int i = 0; i < `DCGO_CH; i++)
            o_corrected_codes[i*`DCGO_N +: `DCGO_N] = out_reg[i];
    end

endmodule // dcgo_datapath

// file: bench/dcgo_assertions.sv
// Assertions on the calibration datapath ports.
// Assumes binding into dcgo_datapath, one clock domain.
`timescale 1ns/1ns
`include "dcgo_map.svh"
module dcgo_checker
    import dcgo_pkg::*;
(
    // Watched ports
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_ce,
    input wire logic i_if_sel,
    input wire logic i_frame_n,
    input wire logic i_load_all_channels_strobe,
    input wire logic [`DCGO_CH*`DCGO_N-1:0] o_corrected_codes,
    input wire logic o_update,
    input wire dcgo_sfr_t o_sfr_wr,
    input wire logic o_sda_oe_n,
    input wire logic o_if_active
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_rst);
    ////////////////////////////////////////
    // Load strobe and double buffer
    a_update_follows: assert property (i_ce && i_load_all_channels_strobe |=> o_update)
        else $error("update missing after strobe");
    a_update_cause: assert property (o_update |-> $past(i_load_all_channels_strobe))
        else $error("update without strobe");
    a_codes_hold: assert property (!o_update |-> $stable(o_corrected_codes))
        else $error("codes moved without update");
    // Interface wake and idle
    a_frame_wakes: assert property (i_if_sel && $fell(i_frame_n) |-> ##[1:3] o_if_active)
        else $error("frame start did not wake");
    a_idle_quiet: assert property ((i_if_sel && i_frame_n) [*4] |-> !o_if_active)
        else $error("active outside frame");
    // Special function register hand-off and serial-mode data line
    a_sfr_pulse: assert property (o_sfr_wr.valid |=> !o_sfr_wr.valid)
        else $error("sfr valid too long");
    a_sfr_after_frame: assert property (o_sfr_wr.valid && i_if_sel |-> $past(i_frame_n))
        else $error("sfr write inside frame");
    a_serial_no_ack: assert property (i_if_sel |-> o_sda_oe_n)
        else $error("data line driven in serial mode");
    // Main scenarios
    c_load: cover property (o_update);
    c_sfr: cover property (o_sfr_wr.valid);
    c_frame: cover property ($rose(o_if_active));
    c_two_wire_ack: cover property (!i_if_sel && !o_sda_oe_n);
endmodule // dcgo_checker

bind dcgo_datapath dcgo_checker dcgo_checker_inst (.i_clk, .i_rst, .i_ce, .i_if_sel, .i_frame_n,
    .i_load_all_channels_strobe, .o_corrected_codes, .o_update, .o_sfr_wr, .o_sda_oe_n, .o_if_active);

// file: bench/dcgo_host.sv
// Host model, master of the serial port and of the two-wire bus.
// Assumes the datapath clock; pins move 1 ns after an edge.
`timescale 1ns/1ns
module dcgo_host
(
    // Clock
    input wire logic i_clk,
    // Serial pins
    output logic o_frame_n,
    output logic o_sclk,
    output logic o_sdin,
    // Two-wire pins, data released when high, line level seen back
    output logic o_scl,
    output logic o_sda,
    input wire logic i_sda
);
    // Idle pins, clock stands low, two-wire lines released
    initial
    begin
        o_frame_n = 1'b1;
        o_sclk = 1'b0;
        o_sdin = 1'b0;
        o_scl = 1'b1;
        o_sda = 1'b1;
    end
    ////////////////////////////////////////
    // Sends nb bits MSB first, hc cycles per clock phase
    task automatic send(input logic [23:0] w, input int nb, input int hc);
        @(posedge i_clk);
        #1 o_frame_n = 1'b0;
        for (int i = 0; i < nb; i++)
        begin
            repeat (hc) @(posedge i_clk);
            #1 o_sclk = 1'b1;
            o_sdin = w[23-i];
            repeat (hc) @(posedge i_clk);
            #1 o_sclk = 1'b0;
        end
        repeat (hc) @(posedge i_clk);
        #1 o_frame_n = 1'b1;
        o_sdin = ~o_sdin; // No stale bit
        repeat (3) @(posedge i_clk);
    endtask

    // Two-wire write: start, address byte, three data bytes, stop; counts acknowledges
    task automatic tw_send(input logic [6:0] a, input logic [23:0] w, output int acks);
        logic [31:0] b;
        b = {a, 1'b0, w};
        acks = 0;
        @(posedge i_clk);
        #1 o_sda = 1'b0; // Start: data falls while clock high
        repeat (2) @(posedge i_clk);
        for (int i = 0; i < 36; i++)
        begin
            #1 o_scl = 1'b0;
            o_sda = (i % 9 == 8) ? 1'b1 : b[31 - (i / 9) * 8 - i % 9];
            repeat (2) @(posedge i_clk);
            #1 o_scl = 1'b1;
            @(posedge i_clk);
            #1 if (i % 9 == 8 && !i_sda) acks++;
            @(posedge i_clk);
        end
        #1 o_scl = 1'b0;
        o_sda = 1'b0;
        repeat (2) @(posedge i_clk);
        #1 o_scl = 1'b1;
        repeat (2) @(posedge i_clk);
        #1 o_sda = 1'b1; // Stop: data rises while clock high
        repeat (3) @(posedge i_clk);
    endtask
endmodule // dcgo_host

// file: bench/testbench.sv
// Bench for the calibration datapath.
// Assumes dcgo_host as serial master and the bound checker.
`timescale 1ns/1ns
`include "dcgo_map.svh"
module testbench
    import dcgo_pkg::*;
;
    // Stimulus, observations, model
    logic i_clk = 1'b0;
    logic i_rst = 1'b1;
    logic sel = 1'b1;
    logic ld = 1'b0;
    logic ce = 1'b1;
    wire logic fr_n, sck, sd;
    wire logic scl, tw_sda;
    logic [`DCGO_CH*`DCGO_N-1:0] codes;
    logic upd, sda_o, sda_oe_n, act;
    // Open-drain data line, pulled up, low when either side pulls
    wire logic sda_line = tw_sda & (sda_oe_n | sda_o);
    int acks = 0;
    dcgo_sfr_t sfr;
    dcgo_sfr_t sfr_seen = '0;
    int sfr_cnt = 0;
    int error_cnt = 0;
    int checks = 0;
    logic [13:0] m [16], c [16], x [16], e [16];
    logic [13:0] gt [6] = '{14'h3FFE, 14'h2FFE, 14'h1FFE, 14'h0FFE, 14'h0000, 14'h1FFF};
    logic [13:0] ot [4] = '{14'h3FFF, 14'h2001, 14'h1FFF, 14'h0000};

    always #5 i_clk = ~i_clk;

    // Design and host
    dcgo_datapath dcgo_datapath_inst (.i_clk, .i_rst, .i_ce(ce), .i_if_sel(sel), .i_frame_n(fr_n),
        .i_sclk(sck), .i_sdin(sd), .i_scl(scl), .i_sda_in(sda_line), .o_sda_out(sda_o), .o_sda_oe_n(sda_oe_n),
        .i_load_all_channels_strobe(ld), .o_corrected_codes(codes), .o_update(upd), .o_sfr_wr(sfr),
        .o_if_active(act));
    dcgo_host dcgo_host_inst (.i_clk, .o_frame_n(fr_n), .o_sclk(sck), .o_sdin(sd), .o_scl(scl), .o_sda(tw_sda),
        .i_sda(sda_line));

    // Captures special function writes
    always @(posedge i_clk)
        if (sfr.valid === 1'b1)
        begin
            sfr_seen <= sfr;
            sfr_cnt <= sfr_cnt + 1;
        end
    ////////////////////////////////////////
    task automatic check(input string what, input logic [18:0] seen, input logic [18:0] exp);
        checks++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
        end
    endtask

    function automatic logic [13:0] calc(input logic [13:0] g, input logic [13:0] v, input logic [13:0] o);
        int r;
        r = (((int'(g) + 2) * int'(v)) >>> 14) + int'(o) - 8192;
        return (r < 0) ? 14'h0000 : (r > 16383) ? 14'h3FFF : 14'(r);
    endfunction

    task automatic cmp_codes();
        for (int i = 0; i < 16; i++)
            check("code", {5'h0, codes[14*i+:14]}, {5'h0, e[i]});
    endtask

    task automatic wr(input logic [3:0] ch, input dcgo_sel_t s, input logic [13:0] d, input int hc);
        dcgo_host_inst.send({4'h0, ch, s, d}, 24, hc);
        if (s == DCGO_SEL_CODE) x[ch] = d;
        if (s == DCGO_SEL_OFFS) c[ch] = d;
        if (s == DCGO_SEL_GAIN) m[ch] = {d[13:1], 1'b0};
    endtask

    task automatic load();
        @(posedge i_clk);
        #1 ld = 1'b1;
        @(posedge i_clk);
        #1 ld = 1'b0;
        for (int i = 0; i < 16; i++) e[i] = calc(m[i], x[i], c[i]);
        check("update", {18'h0, upd}, 19'h1);
        cmp_codes();
    endtask

    task automatic rst(input int n);
        @(posedge i_clk);
        #1 i_rst = 1'b1;
        foreach (m[i])
        begin
            m[i] = 14'h3FFE;
            c[i] = 14'h2000;
            x[i] = 14'h0000;
            e[i] = 14'h0000;
        end
        repeat (n) @(posedge i_clk);
        #1 i_rst = 1'b0;
        check("oe_n", {18'h0, sda_oe_n}, 19'h1);
        check("sfr", sfr, 19'h0);
        check("active", {18'h0, act}, 19'h0);
        check("sda out", {18'h0, sda_o}, 19'h0);
        cmp_codes();
    endtask

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // Main sequence
    initial
    begin
        rst(8);
        load();
        $display("test reset done");
        wr(4'h3, DCGO_SEL_CODE, 14'h1000, 2);
        cmp_codes();
        load();
        wr(4'h5, DCGO_SEL_CODE, 14'h3000, 1);
        wr(4'h7, DCGO_SEL_CODE, 14'h3F00, 1);
        foreach (gt[k])
        begin
            wr(4'h5, DCGO_SEL_GAIN, gt[k], k % 2 + 1);
            load();
        end
        foreach (ot[k])
        begin
            wr(4'h7, DCGO_SEL_OFFS, ot[k], 1);
            load();
        end
        wr(4'h7, DCGO_SEL_CODE, 14'h0100, 1);
        load();
        $display("test coefficients done");
        wr(4'hA, DCGO_SEL_SFR, 14'h2A5C, 2);
        check("sfr", sfr_seen, {1'b1, 4'hA, 14'h2A5C});
        dcgo_host_inst.send({4'h4, 4'h3, DCGO_SEL_CODE, 14'h3333}, 24, 1);
        dcgo_host_inst.send({4'h0, 4'h3, DCGO_SEL_CODE, 14'h2222}, 20, 1);
        #1 sel = 1'b0;
        dcgo_host_inst.send({4'h0, 4'h3, DCGO_SEL_CODE, 14'h1111}, 24, 1);
        dcgo_host_inst.tw_send(`DCGO_TW_ADDR, {4'h0, 4'h9, DCGO_SEL_CODE, 14'h2345}, acks);
        check("acks", 19'(acks), 19'h4);
        x[9] = 14'h2345;
        dcgo_host_inst.tw_send(7'h2B, {4'h0, 4'h9, DCGO_SEL_CODE, 14'h0777}, acks);
        check("acks foreign", 19'(acks), 19'h0);
        #1 sel = 1'b1;
        load();
        check("sfr count", 19'(sfr_cnt), 19'h1);
        $display("test refusals done");
        rst(2);
        wr(4'h5, DCGO_SEL_CODE, 14'h3000, 1);
        load();
        $display("test second reset done");
        @(posedge i_clk);
        #1 ce = 1'b0;
        ld = 1'b1;
        @(posedge i_clk);
        #1 ld = 1'b0;
        check("frozen update", {18'h0, upd}, 19'h0);
        cmp_codes();
        ce = 1'b1;
        $display("test clock enable done");
        end_of_test();
    end

    // Hang limit
    initial
    begin
        #1000000;
        error_cnt++;
        end_of_test();
    end
endmodule // testbench
